// *** rtl/tigc_pkg.sv ***
// shared constants of the time interval gate counter
package tigc_pkg;

   // time-base clock period
   localparam int CLK_PERIOD_NS = 5;

   // shortest start or stop pulse that is recognised
   localparam int MIN_PULSE_NS  = 10;
   // least time rounds up to whole cycles
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // dead time from a stop to the next accepted start
   localparam int DEAD_TIME_NS  = 10;
   localparam int DEAD_CYC      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // minimum start-to-stop interval, in clock periods
   localparam int MIN_INT_CYC   = 1;

   // readout unit codes
   localparam logic [1:0] UNIT_PS   = 2'h0;
   localparam logic [1:0] UNIT_NS   = 2'h1;
   localparam logic [1:0] UNIT_US   = 2'h2;
   localparam logic [1:0] UNIT_MS   = 2'h3;

   // readout unit and decimal point matched to the clock period
   localparam logic [1:0] DISP_UNIT = UNIT_NS;
   localparam logic [3:0] DISP_DP   = 4'h0;

   // clock period in readout units; 1 would mean a power-of-ten clock
   localparam int PERIOD_MANT   = 5;

   // reset values
   localparam logic       VALID_RST = 1'b0;

   // measurement sequencer states
   typedef enum logic [2:0]
   {
      TIGC_ARM  = 3'b001,
      TIGC_OPEN = 3'b010,
      TIGC_DEAD = 3'b100
   } tigc_state_e;

endpackage

// *** rtl/tigc_pulse_qual.sv ***
`timescale 1ns/1ps
`default_nettype none
// one channel: width qualification and one pulse per input cycle
module tigc_pulse_qual #(
   parameter int MIN_W = tigc_pkg::MIN_PULSE_CYC
)(
   input  wire logic clk_i,    // time-base clock
   input  wire logic rstn_i,   // synchronous reset, active low
   input  wire logic level_i,  // conditioned channel level
   input  wire logic fall_i,   // trigger on the falling edge when high
   output var  logic pulse_o   // one-cycle event pulse
);

   localparam int CW = $clog2(MIN_W + 1);

   // refuse widths the counter cannot hold
   if (MIN_W < 1)
   begin : g_chk
      $error("tigc_pulse_qual: MIN_W must be at least 1");
   end

   logic          active;     // level after slope selection
   logic [CW-1:0] run_ff;     // consecutive active cycles, saturating
   logic [CW-1:0] nxt_run;
   logic          pulse_ff;
   logic          nxt_pulse;

   assign active  = level_i ^ fall_i;
   assign pulse_o = pulse_ff;

   // next values: fire once when the level has lasted the minimum width
   always_comb
   begin
      nxt_run   = run_ff;
      nxt_pulse = 1'b0;
      if (!active)
      begin
         nxt_run = '0;
      end
      else if (run_ff != CW'(MIN_W))
      begin
         nxt_run = run_ff + 1'b1;
      end
      // shorter runs never reach the firing count
      if (active && (run_ff == CW'(MIN_W - 1)))
      begin
         nxt_pulse = 1'b1;
      end
   end

   // registers
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         run_ff   <= '0;
         pulse_ff <= 1'b0;
      end
      else
      begin
         run_ff   <= nxt_run;
         pulse_ff <= nxt_pulse;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // a pulse never lasts more than one cycle
   AST_QUAL_ONE: assert property (pulse_o |=> !pulse_o)
      else $error("qualified pulse longer than one cycle");

   // a one-cycle input is treated as absent
   if (MIN_W >= 2)
   begin : g_short
      AST_QUAL_SHORT: assert property ((!active ##1 active ##1 !active) |=> !pulse_o)
         else $error("runt input produced a pulse");
   end

endmodule
`default_nettype wire

// *** rtl/tigc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module tigc_core #(
   parameter int CNT_W = 32,  // interval counter width
   parameter int AVG_W = 4    // width of the averaging exponent
)(
   input  wire logic                   clk_i,          // time-base clock
   input  wire logic                   rstn_i,         // synchronous reset, active low
   input  wire logic                   start_i,        // start channel level
   input  wire logic                   stop_i,         // stop channel level
   input  wire logic                   common_i,       // start input drives both channels
   input  wire logic                   avg_mode_i,     // averaging mode
   input  wire logic [AVG_W-1:0]       avg_log2_i,     // log2 of intervals averaged
   output var  logic                   ready_o,        // start would be accepted
   output var  logic                   gate_o,         // gate open
   output var  logic                   result_valid_o, // one-cycle result strobe
   output var  logic [CNT_W-1:0]       raw_count_o,    // mean count in clock periods
   output var  logic [CNT_W+(1<<AVG_W)-2:0] sum_count_o, // accumulated count
   output var  logic [CNT_W+(1<<AVG_W)+2:0] scaled_count_o, // interval in readout units
   output var  logic [1:0]             disp_unit_o,    // readout unit code
   output var  logic [3:0]             disp_dp_o       // digits right of the point
);

   localparam int IDX_W = 1 << AVG_W;         // interval index width
   localparam int ACC_W = CNT_W + IDX_W - 1;  // room for the largest sum
   localparam int SC_W  = ACC_W + 4;          // sum times period mantissa

   // refuse sizes the logic cannot serve
   if ((CNT_W < 8) || (AVG_W < 1) || (AVG_W > 5) || (tigc_pkg::PERIOD_MANT < 1) ||
       (tigc_pkg::PERIOD_MANT > 15) || (tigc_pkg::DEAD_CYC < 1) ||
       (tigc_pkg::DEAD_CYC > 4))
   begin : g_chk
      $error("tigc_core: unsupported parameter values");
   end

   // ---------------------------------------------------------------
   // synchronizers for the averaging path
   // ---------------------------------------------------------------
   logic [1:0] sync1_ff;   // first stage, read only by the second
   logic [1:0] sync2_ff;   // second stage
   logic [1:0] nxt_sync1;
   logic [1:0] nxt_sync2;

   // next values of the two-stage chain
   always_comb
   begin
      nxt_sync1 = {stop_i, start_i};
      nxt_sync2 = sync1_ff;
   end

   // synchronizer registers
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         sync1_ff <= 2'h0;
         sync2_ff <= 2'h0;
      end
      else
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end

   logic sel_start;  // start level in use
   logic sel_stop;   // stop level in use
   logic start_pls;  // qualified start event
   logic stop_pls;   // qualified stop event

   // averaging takes the synchronized copies
   assign sel_start = avg_mode_i ? sync2_ff[0] : start_i;
   // common mode: stop channel watches the start input's falling edge
   assign sel_stop  = common_i ? sel_start :
                      (avg_mode_i ? sync2_ff[1] : stop_i);

   // start channel, rising edge
   tigc_pulse_qual #(
      .MIN_W (tigc_pkg::MIN_PULSE_CYC)
   ) u_start_qual (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .level_i (sel_start),
      .fall_i  (1'b0),
      .pulse_o (start_pls)
   );

   // stop channel, falling edge in common mode for pulse width
   tigc_pulse_qual #(
      .MIN_W (tigc_pkg::MIN_PULSE_CYC)
   ) u_stop_qual (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .level_i (sel_stop),
      .fall_i  (common_i),
      .pulse_o (stop_pls)
   );

   // ---------------------------------------------------------------
   // measurement sequencer
   // ---------------------------------------------------------------
   tigc_pkg::tigc_state_e state_ff;       // sequencer state
   tigc_pkg::tigc_state_e nxt_state;
   logic [CNT_W-1:0]      cnt_ff;         // clocks since start
   logic [CNT_W-1:0]      nxt_cnt;
   logic [1:0]            dead_ff;        // dead time remaining
   logic [1:0]            nxt_dead;
   logic [IDX_W-1:0]      idx_ff;         // intervals taken in this average
   logic [IDX_W-1:0]      nxt_idx;
   logic [ACC_W-1:0]      acc_ff;         // running sum of intervals
   logic [ACC_W-1:0]      nxt_acc;
   logic                  valid_ff;
   logic                  nxt_valid;
   logic [CNT_W-1:0]      raw_ff;
   logic [CNT_W-1:0]      nxt_raw;
   logic [ACC_W-1:0]      sum_ff;
   logic [ACC_W-1:0]      nxt_sum;
   logic [SC_W-1:0]       scaled_ff;
   logic [SC_W-1:0]       nxt_scaled;

   logic [CNT_W-1:0]      intv;           // interval if stop lands now
   logic                  stop_ok;        // stop accepted this cycle
   logic [IDX_W-1:0]      n_m1;           // intervals per average minus one
   logic [AVG_W-1:0]      shift;          // divide exponent in use
   logic [ACC_W-1:0]      sum_full;       // sum including this interval
   logic [SC_W-1:0]       prod;           // sum in readout units

   // interval is clocks between the start and stop cycles, saturating
   assign intv     = (cnt_ff == '1) ? cnt_ff : cnt_ff + 1'b1;
   // a stop earlier than the minimum interval is not recognised
   assign stop_ok  = (state_ff == tigc_pkg::TIGC_OPEN) && stop_pls &&
                     (cnt_ff >= CNT_W'(tigc_pkg::MIN_INT_CYC - 1));
   assign n_m1     = ~({IDX_W{1'b1}} << avg_log2_i);
   assign shift    = avg_mode_i ? avg_log2_i : '0;
   assign sum_full = acc_ff + ACC_W'(intv);
   // multiply before dividing so fractions of a period survive
   assign prod     = SC_W'(sum_full) * SC_W'(tigc_pkg::PERIOD_MANT);

   // next values of the sequencer
   always_comb
   begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_dead   = dead_ff;
      nxt_idx    = idx_ff;
      nxt_acc    = acc_ff;
      nxt_valid  = 1'b0;
      nxt_raw    = raw_ff;
      nxt_sum    = sum_ff;
      nxt_scaled = scaled_ff;
      case (state_ff)
         tigc_pkg::TIGC_ARM:
         begin
            // stops here are ignored; a start opens the gate
            nxt_cnt = '0;
            if (start_pls)
            begin
               nxt_state = tigc_pkg::TIGC_OPEN;
            end
         end
         tigc_pkg::TIGC_OPEN:
         begin
            if (stop_ok)
            begin
               // gate closes, dead time begins
               nxt_state = tigc_pkg::TIGC_DEAD;
               nxt_dead  = 2'(tigc_pkg::DEAD_CYC - 1);
               nxt_cnt   = '0;
               if (!avg_mode_i || (idx_ff == n_m1))
               begin
                  // result: sum divided by the count of intervals
                  nxt_valid  = 1'b1;
                  nxt_sum    = sum_full;
                  nxt_raw    = CNT_W'(sum_full >> shift);
                  nxt_scaled = prod >> shift;
                  nxt_idx    = '0;
                  nxt_acc    = '0;
               end
               else
               begin
                  nxt_idx = idx_ff + 1'b1;
                  nxt_acc = sum_full;
               end
            end
            else if (cnt_ff != '1)
            begin
               // early stops fall through: counting goes on
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         tigc_pkg::TIGC_DEAD:
         begin
            // starts are refused until the dead time has run out
            if (dead_ff == 2'h0)
            begin
               nxt_state = tigc_pkg::TIGC_ARM;
            end
            else
            begin
               nxt_dead = dead_ff - 1'b1;
            end
         end
         default:
         begin
            nxt_state = tigc_pkg::TIGC_ARM;
            nxt_cnt   = '0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         state_ff  <= tigc_pkg::TIGC_ARM;
         cnt_ff    <= '0;
         dead_ff   <= 2'h0;
         idx_ff    <= '0;
         acc_ff    <= '0;
         valid_ff  <= tigc_pkg::VALID_RST;
         raw_ff    <= '0;
         sum_ff    <= '0;
         scaled_ff <= '0;
      end
      else
      begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         dead_ff   <= nxt_dead;
         idx_ff    <= nxt_idx;
         acc_ff    <= nxt_acc;
         valid_ff  <= nxt_valid;
         raw_ff    <= nxt_raw;
         sum_ff    <= nxt_sum;
         scaled_ff <= nxt_scaled;
      end
   end

   // outputs
   assign ready_o        = (state_ff == tigc_pkg::TIGC_ARM);
   assign gate_o         = (state_ff == tigc_pkg::TIGC_OPEN);
   assign result_valid_o = valid_ff;
   assign raw_count_o    = raw_ff;
   assign sum_count_o    = sum_ff;
   assign scaled_count_o = scaled_ff;
   assign disp_unit_o    = tigc_pkg::DISP_UNIT;
   assign disp_dp_o      = tigc_pkg::DISP_DP;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence seq_start_taken;
      ready_o && start_pls;
   endsequence

   sequence seq_stop_taken;
      stop_ok;
   endsequence

   AST_GATE_OPENS: assert property (seq_start_taken |=> gate_o && (cnt_ff == '0))
      else $error("start did not open an empty gate");

   AST_COUNT_RUNS: assert property ((gate_o && !stop_ok && (cnt_ff != '1)) |=>
                                    (gate_o && (cnt_ff == $past(cnt_ff) + 1'b1)))
      else $error("gate closed or count stalled without a stop");

   AST_SINGLE_RESULT: assert property ((seq_stop_taken and !avg_mode_i) |=>
                                       (result_valid_o && (raw_count_o == $past(intv))))
      else $error("single-shot result missing or wrong");

   AST_SCALED: assert property ((result_valid_o && !$past(avg_mode_i)) |->
                                (scaled_count_o ==
                                 SC_W'(raw_count_o) * SC_W'(tigc_pkg::PERIOD_MANT)))
      else $error("scaled readout does not match the count");

   AST_DEAD_TIME: assert property (seq_stop_taken |=> (!ready_o && !gate_o)[*2] ##1 ready_o)
      else $error("dead time length wrong");

   AST_ARM_IGNORES_STOP: assert property ((ready_o && stop_pls && !start_pls) |=>
                                          (ready_o && !result_valid_o))
      else $error("stop acted without a start");

   AST_CLEARED: assert property (ready_o |-> (cnt_ff == '0))
      else $error("counter not empty while armed");

   AST_AVG_WAIT: assert property ((seq_stop_taken and (avg_mode_i && (idx_ff != n_m1))) |=>
                                  (!result_valid_o && (acc_ff == $past(sum_full))))
      else $error("average reported before N intervals");

   AST_VALID_PULSE: assert property (result_valid_o |=> !result_valid_o && !gate_o)
      else $error("result strobe longer than one cycle");

endmodule
`default_nettype wire

// *** test/tigc_chan_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// trigger channel model: one conditioned pulse per command
module tigc_chan_model (
   input  wire logic clk_i,   // time-base clock
   output var  logic level_o  // conditioned channel level
);
   // trigger output rests low between pulses
   initial level_o = 1'b0;

   // wait dly falling edges, then stay high for wid cycles; a width
   // under the minimum is asked for only where a glitch is meant
   task automatic fire(input int dly, input int wid);
      repeat (dly) @(negedge clk_i);
      level_o = 1'b1;
      repeat (wid) @(negedge clk_i);
      level_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** test/tigc_core_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// self-checking bench of the gate counter
module tigc_core_bench;
   localparam int CW = 32;              // counter width
   localparam int AW = 4;               // averaging exponent width

   logic                  clk_i;          // time-base clock
   logic                  rstn_i;         // reset, active low
   logic                  start_i;        // start channel level
   logic                  stop_i;         // stop channel level
   logic                  common_i;       // one input for both channels
   logic                  avg_mode_i;     // averaging mode
   logic [AW-1:0]         avg_log2_i;     // log2 of intervals averaged
   logic                  ready_o;        // armed
   logic                  gate_o;         // gate open
   logic                  result_valid_o; // result strobe
   logic [CW-1:0]         raw_count_o;    // mean count
   logic [CW+(1<<AW)-2:0] sum_count_o;    // accumulated count
   logic [CW+(1<<AW)+2:0] scaled_count_o; // interval in readout units
   logic [1:0]            disp_unit_o;    // readout unit
   logic [3:0]            disp_dp_o;      // decimal point
   int                    fail_count;     // mismatches seen
   int                    compares;       // comparisons made
   logic [63:0]           got_raw;        // captured mean count
   logic [63:0]           got_sum;        // captured sum
   logic [63:0]           got_scl;        // captured scaled count
   logic                  got_vld;        // a strobe was seen
   logic                  gate_seen;      // gate opened at some point

   // design under test
   tigc_core #(.CNT_W(CW), .AVG_W(AW)) u_tigc_core (
      .clk_i          (clk_i),
      .rstn_i         (rstn_i),
      .start_i        (start_i),
      .stop_i         (stop_i),
      .common_i       (common_i),
      .avg_mode_i     (avg_mode_i),
      .avg_log2_i     (avg_log2_i),
      .ready_o        (ready_o),
      .gate_o         (gate_o),
      .result_valid_o (result_valid_o),
      .raw_count_o    (raw_count_o),
      .sum_count_o    (sum_count_o),
      .scaled_count_o (scaled_count_o),
      .disp_unit_o    (disp_unit_o),
      .disp_dp_o      (disp_dp_o)
   );

   // start and stop trigger channels
   tigc_chan_model u_tigc_chan_model_start (.clk_i(clk_i), .level_o(start_i));
   tigc_chan_model u_tigc_chan_model_stop  (.clk_i(clk_i), .level_o(stop_i));

   // 200 MHz time base
   always #2.5 clk_i = ~clk_i;

   // compare a count
   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // compare a flag
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   // print counts and verdict, then stop
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // stop channel pattern: 0 one stop, 1 none, 2 coincident then glitch then good
   task automatic stop_seq(input int d, input int md);
      if (md == 0 || md == 3)
      begin
         u_tigc_chan_model_stop.fire(d, 3);
      end
      else if (md == 2)
      begin
         u_tigc_chan_model_stop.fire(0, 2); // same cycle as start, gate shut
         u_tigc_chan_model_stop.fire(2, 1); // one-cycle glitch at cycle 4
         u_tigc_chan_model_stop.fire(5, 2); // first valid stop, cycle 10
      end
   endtask

   // one start/stop pair; md 3 adds a start inside the dead time
   task automatic measure(input int d, input int ws, input int md);
      got_vld = 1'b0;
      gate_seen = 1'b0;
      fork
         begin
            u_tigc_chan_model_start.fire(0, ws);
            if (md == 3) u_tigc_chan_model_start.fire(3, 3);
         end
         stop_seq(d, md);
      join_none
      for (int i = 0; i < 80; i++)
      begin
         @(negedge clk_i);
         if (gate_o === 1'b1) gate_seen = 1'b1;
         if (result_valid_o === 1'b1)
         begin
            got_vld = 1'b1;
            got_raw = 64'(raw_count_o);
            got_sum = 64'(sum_count_o);
            got_scl = 64'(scaled_count_o);
         end
         if (i > d + ws + 4 && ready_o === 1'b1) break;
      end
      wait fork;
   endtask

   // result expected from a sum of counts over 2**lg intervals
   task automatic check_res(input longint sum, input int lg);
      cmp_bit("result strobe", 1'b1, got_vld);
      cmp_bit("gate opened", 1'b1, gate_seen);
      cmp("raw count", 64'(sum >> lg), got_raw);
      cmp("sum count", 64'(sum), got_sum);
      cmp("scaled count", 64'((sum * tigc_pkg::PERIOD_MANT) >> lg), got_scl);
   endtask

   // idle state and readout constants after reset
   task automatic t_reset();
      cmp_bit("ready", 1'b1, ready_o);
      cmp_bit("gate", 1'b0, gate_o);
      cmp_bit("strobe", 1'b0, result_valid_o);
      cmp("raw", 64'h0, 64'(raw_count_o));
      cmp("unit", 64'(tigc_pkg::DISP_UNIT), 64'(disp_unit_o));
      cmp("point", 64'(tigc_pkg::DISP_DP), 64'(disp_dp_o));
      $display("test reset done");
   endtask

   // back-to-back single shots, shortest interval first
   task automatic t_single();
      int ds[3] = '{1, 4, 37};
      foreach (ds[k])
      begin
         measure(ds[k], 3, 0);
         check_res(ds[k], 0);
      end
      $display("test single done");
   endtask

   // early and short stops are passed over
   task automatic t_early();
      measure(10, 3, 2);
      check_res(10, 0);
      $display("test early done");
   endtask

   // start one cycle after stop taken is refused
   task automatic t_dead();
      measure(5, 3, 3);
      check_res(5, 0);
      repeat (10) @(negedge clk_i);
      cmp_bit("gate after refused start", 1'b0, gate_o);
      cmp_bit("ready after refused start", 1'b1, ready_o);
      $display("test dead done");
   endtask

   // pulse width on one input
   task automatic t_common();
      common_i = 1'b1;
      repeat (4) @(negedge clk_i);
      measure(10, 10, 1);
      check_res(10, 0);
      common_i = 1'b0;
      repeat (4) @(negedge clk_i);
      $display("test common done");
   endtask

   // four intervals averaged, mean between two period steps (3.75 periods)
   task automatic t_avg();
      int ds[4] = '{3, 4, 4, 4};
      avg_mode_i = 1'b1;
      avg_log2_i = 4'h2;
      repeat (4) @(negedge clk_i);
      foreach (ds[k])
      begin
         measure(ds[k], 3, 0);
         if (k < 3) cmp_bit("early average strobe", 1'b0, got_vld);
      end
      check_res(15, 2);
      $display("test average done");
   endtask

   // main sequence
   initial
   begin
      fail_count = 0;
      compares = 0;
      clk_i = 1'b0;
      rstn_i = 1'b0;
      common_i = 1'b0;
      avg_mode_i = 1'b0;
      avg_log2_i = 4'h0;
      repeat (5) @(negedge clk_i);
      rstn_i = 1'b1;
      @(negedge clk_i);
      t_reset();
      t_single();
      t_early();
      t_dead();
      t_common();
      t_avg();
      wrap_up();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
